// File: dcp_pkg.sv
// Constants and types shared by the command and address front end
package dcp_pkg;

  // ------------------------------------------------------------------
  // Organisation
  // ------------------------------------------------------------------
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned ROW_W_X16 = 14;
  localparam int unsigned ROW_W_X8 = 15;
  localparam int unsigned COL_W = 10;
  localparam int unsigned ORG_X16 = 16;
  localparam int unsigned ORG_X8 = 8;
  localparam int unsigned PAGE_BYTES_X16 = (2 ** COL_W) * ORG_X16 / 8;
  localparam int unsigned PAGE_BYTES_X8 = (2 ** COL_W) * ORG_X8 / 8;
  localparam int unsigned PAGE_W = 12;

  // ------------------------------------------------------------------
  // Address bit positions
  // ------------------------------------------------------------------
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned BC_BIT = 12;
  localparam int unsigned TDQS_EN_BIT = 11;
  localparam int unsigned MR1_RTT_LO_BIT = 2;
  localparam int unsigned MR1_RTT_MID_BIT = 6;
  localparam int unsigned MR1_RTT_HI_BIT = 9;
  localparam int unsigned MR2_RTTWR_LO_BIT = 9;
  localparam int unsigned MR2_RTTWR_HI_BIT = 10;
  localparam int unsigned NUM_MR = 4;
  localparam int unsigned MR_SEL_W = 2;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MR_RESET = 15'h0000;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 8'h00;

  // ------------------------------------------------------------------
  // Commands: {cs_b, ras_b, cas_b, we_b}
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_ZQC = 4'h6,
    CMD_NOP = 4'h7,
    CMD_DES = 4'h8
  } dcp_cmd_t;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h0,
    PWR_PRE_PD = 3'h1,
    PWR_ACT_PD = 3'h2,
    PWR_SELF_REF = 3'h3
  } dcp_pwr_t;

endpackage : dcp_pkg

// File: dcp_bank_row.sv
// One bank's open row tracker
`timescale 1ns/100ps
`default_nettype none
module dcp_bank_row
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic open_en,
  input wire logic close_en,
  input wire logic [ADDR_W-1:0] row_in,
  // State
  output logic is_open,
  output logic [ADDR_W-1:0] row_out
);

  logic open_reg;
  logic open_next;
  logic [ADDR_W-1:0] row_reg;
  logic [ADDR_W-1:0] row_next;

  always_comb begin
    open_next = open_reg;
    row_next = row_reg;
    if (open_en) begin
      open_next = 1'b1;
      row_next = row_in;
    end else if (close_en) begin
      open_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      open_reg <= 1'b0;
      row_reg <= '0;
    end else begin
      open_reg <= open_next;
      row_reg <= row_next;
    end
  end

  assign is_open = open_reg;
  assign row_out = row_reg;

endmodule : dcp_bank_row
`default_nettype wire

// File: dcp_dm_sampler.sv
// Write data mask capture on both strobe edges
`timescale 1ns/100ps
`default_nettype none
module dcp_dm_sampler
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Strobe edges in core time
  input wire logic wr_active,
  input wire logic dqs_rise,
  input wire logic dqs_fall,
  input wire logic dm_in,
  // Result
  output logic word_valid,
  output logic word_keep
);

  logic valid_reg;
  logic valid_next;
  logic keep_reg;
  logic keep_next;

  // Both edges carry a data beat; a mask high at the beat drops it
  always_comb begin
    valid_next = 1'b0;
    keep_next = keep_reg;
    if (wr_active && (dqs_rise || dqs_fall)) begin // see [RQ13]
      valid_next = 1'b1;
      keep_next = ~dm_in; // see [RQ12]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      valid_reg <= 1'b0;
      keep_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      keep_reg <= keep_next;
    end
  end

  assign word_valid = valid_reg;
  assign word_keep = keep_reg;

endmodule : dcp_dm_sampler
`default_nettype wire

// File: dcp_cmd_front.sv
// Command, address and control pin front end of the memory device
// Overview of operation
// [RQ1] Sample every address and control input on the rising clock edge.
// [RQ2] Clock enable high runs clocks, buffers and drivers; low stops them.
// [RQ3] Enable low with banks idle gives precharge power-down or self-refresh; else active. Here a refresh enters self-refresh even with banks open.
// [RQ4] Self-refresh exit follows enable rising without clock sampling. Here exit is taken on the rising clock edge that samples enable high.
// [RQ5] Controller keeps clock enable high throughout reads and writes.
// [RQ6] Power-down gates all inputs except clock, termination, enable and reset.
// [RQ7] Self-refresh gates all inputs except enable and reset.
// [RQ8] Chip select high masks the command; it is part of the code.
// [RQ9] Decode the command each cycle from row, column, write strobes and select.
// [RQ10] Termination request with termination enabled terminates data, strobes and mask.
// [RQ11] Termination request ignored when mode registers disable it or in self-refresh.
// [RQ12] Write data words with mask high are discarded.
// [RQ13] Mask is sampled on both strobe edges.
// [RQ14] Mode bit 11 of MR1 selects termination strobe or data mask on x8.
// [RQ15] Three bank bits select one of eight banks for bank commands.
// [RQ16] Bank bits choose the mode register written by a mode set.
// [RQ17] Row on activate, column on access; row 14 or 15 bits, column 10.
// [RQ18] Mode set takes its opcode from the address inputs.
// [RQ19] Activate opens one page: 2KB on x16, 1KB on x8.
// [RQ20] Address bit 10 on access requests auto-precharge of that bank.
// [RQ21] Address bit 10 on precharge selects all banks, else one bank.
// [RQ22] Address bit 12 on access selects full burst high, chopped low.
// [RQ23] Reset low is asynchronous, destructive; controller holds it high normally. Here reset is sampled on the rising clock edge.
// [RQ24] Controller keeps chip select high whenever it issues no command.
`timescale 1ns/100ps
`default_nettype none
module dcp_cmd_front
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Organisation strap, high for x8
  input wire logic org_x8,
  // Command pins
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic odt,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  // Write strobe edges and data mask
  input wire logic dqs_rise,
  input wire logic dqs_fall,
  input wire logic dm_tdqs,
  // Decoded command
  output dcp_cmd_t cmd_out,
  output logic cmd_valid,
  output logic [BANK_W-1:0] cmd_bank,
  output logic [ADDR_W-1:0] cmd_row,
  output logic [COL_W-1:0] cmd_col,
  output logic cmd_auto_pre,
  output logic cmd_pre_all,
  output logic cmd_burst_full,
  output logic [PAGE_W-1:0] page_bytes,
  // Mode register write
  output logic mr_wr,
  output logic [MR_SEL_W-1:0] mr_sel,
  output logic [ADDR_W-1:0] mr_opcode,
  // Bank and power state
  output logic [NUM_BANKS-1:0] bank_open,
  output dcp_pwr_t pwr_state,
  output logic clk_run,
  output logic in_buf_en,
  output logic out_drv_en,
  output logic odt_buf_en,
  // Termination and mask
  output logic term_dq,
  output logic term_tdqs,
  output logic tdqs_mode,
  output logic wr_word_valid,
  output logic wr_word_keep
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  dcp_pwr_t pwr_reg;
  dcp_pwr_t pwr_next;
  logic cke_reg;
  logic cke_next;
  dcp_cmd_t cmd_reg;
  dcp_cmd_t cmd_next;
  logic valid_reg;
  logic valid_next;
  logic [BANK_W-1:0] bank_reg;
  logic [BANK_W-1:0] bank_next;
  logic [ADDR_W-1:0] row_reg;
  logic [ADDR_W-1:0] row_next;
  logic [COL_W-1:0] col_reg;
  logic [COL_W-1:0] col_next;
  logic ap_reg;
  logic ap_next;
  logic pall_reg;
  logic pall_next;
  logic bl_reg;
  logic bl_next;
  logic [ADDR_W-1:0] mr_reg [NUM_MR];
  logic [ADDR_W-1:0] mr_next [NUM_MR];
  logic mrw_reg;
  logic mrw_next;
  logic wr_act_reg;
  logic wr_act_next;
  logic term_reg;
  logic term_next;

  logic [NUM_BANKS-1:0] open_vec;
  logic [NUM_BANKS-1:0] open_en;
  logic [NUM_BANKS-1:0] close_en;
  logic [ADDR_W-1:0] row_mask;
  logic [3:0] code;
  dcp_cmd_t dec;
  logic sel_ok;
  logic odt_on;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign code = {cs_b, ras_b, cas_b, we_b}; // see [RQ9]
  // Gated inputs are not looked at outside the active state
  assign sel_ok = (pwr_reg == PWR_ACTIVE) && cke; // see [RQ6] see [RQ7]
  assign row_mask = org_x8 ? 15'h7fff : 15'h3fff; // see [RQ17]

  always_comb begin
    dec = CMD_DES;
    if (!cs_b) begin // see [RQ8]
      unique case (code[2:0])
        3'h0: dec = CMD_MRS;
        3'h1: dec = CMD_REF;
        3'h2: dec = CMD_PRE;
        3'h3: dec = CMD_ACT;
        3'h4: dec = CMD_WR;
        3'h5: dec = CMD_RD;
        3'h6: dec = CMD_ZQC;
        3'h7: dec = CMD_NOP;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Command capture, one edge per command
  // ------------------------------------------------------------------
  always_comb begin
    cmd_next = CMD_DES;
    valid_next = 1'b0;
    bank_next = bank_reg;
    row_next = row_reg;
    col_next = col_reg;
    ap_next = 1'b0;
    pall_next = 1'b0;
    bl_next = bl_reg;
    mrw_next = 1'b0;
    for (int i = 0; i < NUM_MR; i++) begin
      mr_next[i] = mr_reg[i];
    end
    open_en = '0;
    close_en = '0;
    if (sel_ok && dec != CMD_DES && dec != CMD_NOP) begin // see [RQ1]
      cmd_next = dec;
      valid_next = 1'b1;
      bank_next = bank_addr; // see [RQ15]
      unique case (dec)
        CMD_ACT: begin
          row_next = addr & row_mask; // see [RQ17]
          open_en[bank_addr] = 1'b1; // see [RQ19]
        end
        CMD_RD, CMD_WR: begin
          col_next = addr[COL_W-1:0];
          ap_next = addr[AP_BIT]; // see [RQ20]
          bl_next = addr[BC_BIT]; // see [RQ22]
          if (addr[AP_BIT]) begin
            close_en[bank_addr] = 1'b1;
          end
        end
        CMD_PRE: begin
          pall_next = addr[AP_BIT]; // see [RQ21]
          if (addr[AP_BIT]) begin
            close_en = '1;
          end else begin
            close_en[bank_addr] = 1'b1;
          end
        end
        CMD_MRS: begin
          mrw_next = 1'b1;
          mr_next[bank_addr[MR_SEL_W-1:0]] = addr; // see [RQ16] see [RQ18]
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Power state
  // ------------------------------------------------------------------
  always_comb begin
    pwr_next = pwr_reg;
    cke_next = cke;
    unique case (pwr_reg)
      PWR_ACTIVE: begin
        if (cke_reg && !cke) begin // see [RQ2]
          // Refresh with enable falling enters self-refresh
          if (!cs_b && code[2:0] == 3'h1) begin
            pwr_next = PWR_SELF_REF;
          end else if (open_vec == BANKS_IDLE) begin // see [RQ3]
            pwr_next = PWR_PRE_PD;
          end else begin
            pwr_next = PWR_ACT_PD;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD: begin
        if (cke) begin
          pwr_next = PWR_ACTIVE;
        end
      end
      PWR_SELF_REF: begin
        // Exit sees the level, not a registered edge of it
        if (cke) begin // see [RQ4]
          pwr_next = PWR_ACTIVE;
        end
      end
      default: pwr_next = PWR_ACTIVE;
    endcase
  end

  // ------------------------------------------------------------------
  // Termination and write tracking
  // ------------------------------------------------------------------
  assign odt_on = (mr_reg[1][MR1_RTT_LO_BIT] | mr_reg[1][MR1_RTT_MID_BIT] |
                   mr_reg[1][MR1_RTT_HI_BIT] | mr_reg[2][MR2_RTTWR_LO_BIT] |
                   mr_reg[2][MR2_RTTWR_HI_BIT]);

  always_comb begin
    term_next = 1'b0;
    if (odt_on && odt && pwr_reg != PWR_SELF_REF) begin // see [RQ10] see [RQ11]
      term_next = 1'b1;
    end
    wr_act_next = wr_act_reg;
    if (valid_next && cmd_next == CMD_WR) begin
      wr_act_next = 1'b1;
    end else if (valid_next || !cke) begin
      // Relies on the controller holding enable high across the burst
      wr_act_next = 1'b0; // see [RQ5]
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ23]
      pwr_reg <= PWR_ACTIVE;
      cke_reg <= 1'b0;
      cmd_reg <= CMD_DES;
      valid_reg <= 1'b0;
      bank_reg <= '0;
      row_reg <= '0;
      col_reg <= '0;
      ap_reg <= 1'b0;
      pall_reg <= 1'b0;
      bl_reg <= 1'b1;
      mrw_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      term_reg <= 1'b0;
      for (int i = 0; i < NUM_MR; i++) begin
        mr_reg[i] <= MR_RESET;
      end
    end else begin
      pwr_reg <= pwr_next;
      cke_reg <= cke_next;
      cmd_reg <= cmd_next;
      valid_reg <= valid_next;
      bank_reg <= bank_next;
      row_reg <= row_next;
      col_reg <= col_next;
      ap_reg <= ap_next;
      pall_reg <= pall_next;
      bl_reg <= bl_next;
      mrw_reg <= mrw_next;
      wr_act_reg <= wr_act_next;
      term_reg <= term_next;
      for (int i = 0; i < NUM_MR; i++) begin
        mr_reg[i] <= mr_next[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Banks and mask sampler
  // ------------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    dcp_bank_row u_row (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .open_en(open_en[b]),
      .close_en(close_en[b]),
      .row_in(addr & row_mask),
      .is_open(open_vec[b]),
      .row_out()
    );
  end

  dcp_dm_sampler u_dm (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_active(wr_act_reg && !tdqs_mode),
    .dqs_rise(dqs_rise),
    .dqs_fall(dqs_fall),
    .dm_in(dm_tdqs),
    .word_valid(wr_word_valid),
    .word_keep(wr_word_keep)
  );

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign cmd_out = cmd_reg;
  assign cmd_valid = valid_reg;
  assign cmd_bank = bank_reg;
  assign cmd_row = row_reg;
  assign cmd_col = col_reg;
  assign cmd_auto_pre = ap_reg;
  assign cmd_pre_all = pall_reg;
  assign cmd_burst_full = bl_reg;
  assign page_bytes = org_x8 ? PAGE_W'(PAGE_BYTES_X8) : PAGE_W'(PAGE_BYTES_X16); // see [RQ19]
  assign mr_wr = mrw_reg;
  assign mr_sel = bank_reg[MR_SEL_W-1:0];
  assign mr_opcode = mr_reg[bank_reg[MR_SEL_W-1:0]];
  assign bank_open = open_vec;
  assign pwr_state = pwr_reg;
  assign clk_run = (pwr_reg == PWR_ACTIVE); // see [RQ2]
  assign in_buf_en = (pwr_reg == PWR_ACTIVE); // see [RQ6]
  assign out_drv_en = (pwr_reg == PWR_ACTIVE);
  assign odt_buf_en = (pwr_reg != PWR_SELF_REF); // see [RQ7]
  // Mask function is lost on x8 when the pin serves as termination strobe
  assign tdqs_mode = org_x8 & mr_reg[1][TDQS_EN_BIT]; // see [RQ14]
  assign term_dq = term_reg;
  assign term_tdqs = term_reg & tdqs_mode; // see [RQ14]

endmodule : dcp_cmd_front
`default_nettype wire

// File: dcp_ctrl_model.sv
// Memory controller model that drives the command, address and strobe pins
`timescale 1ns/100ps
`default_nettype none
module dcp_ctrl_model
  import dcp_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Command pins
  output var logic cke,
  output var logic cs_b,
  output var logic ras_b,
  output var logic cas_b,
  output var logic we_b,
  output var logic odt,
  output var logic [BANK_W-1:0] bank_addr,
  output var logic [ADDR_W-1:0] addr,
  // Write strobe edges and mask
  output var logic dqs_rise,
  output var logic dqs_fall,
  output var logic dm_tdqs
);
  initial begin
    {cke, cs_b, ras_b, cas_b, we_b} = 5'h1f;
    odt = 1'b0;
    bank_addr = 3'h0;
    addr = 15'h0000;
    {dqs_rise, dqs_fall, dm_tdqs} = 3'h0;
  end

  // One command cycle, then a deselect with the clock enable left at k
  task cmd(input logic [3:0] c, input logic k, input logic [BANK_W-1:0] b,
           input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    #1;
    {cs_b, ras_b, cas_b, we_b} = c;
    cke = k;
    bank_addr = b;
    addr = a;
    @(posedge core_clk);
    #1;
    // No stale address after the command cycle
    {cs_b, ras_b, cas_b, we_b} = 4'hf;
    bank_addr = ~b;
    addr = ~a;
  endtask : cmd

  // One strobe edge with its mask level
  task strobe(input logic r, input logic d);
    @(posedge core_clk);
    #1;
    dqs_rise = r;
    dqs_fall = !r;
    dm_tdqs = d;
    @(posedge core_clk);
    #1;
    {dqs_rise, dqs_fall} = 2'h0;
    dm_tdqs = ~d;
  endtask : strobe
endmodule : dcp_ctrl_model
`default_nettype wire

// File: dcp_cmd_front_asserts.sv
// Port level checks of the command front end
`timescale 1ns/100ps
`default_nettype none
module dcp_cmd_front_asserts
  import dcp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pins
  input wire logic org_x8,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dm_tdqs,
  // Outputs
  input wire dcp_cmd_t cmd_out,
  input wire logic cmd_valid,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic [ADDR_W-1:0] cmd_row,
  input wire logic cmd_pre_all,
  input wire logic [PAGE_W-1:0] page_bytes,
  input wire logic mr_wr,
  input wire logic [MR_SEL_W-1:0] mr_sel,
  input wire logic [ADDR_W-1:0] mr_opcode,
  input wire logic [NUM_BANKS-1:0] bank_open,
  input wire dcp_pwr_t pwr_state,
  input wire logic clk_run,
  input wire logic in_buf_en,
  input wire logic odt_buf_en,
  input wire logic wr_word_valid,
  input wire logic wr_word_keep
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_taken;
    pwr_state == PWR_ACTIVE && cke && !cs_b && {ras_b, cas_b, we_b} != 3'h7;
  endsequence
  sequence s_pd_open;
    pwr_state == PWR_ACTIVE && !cke && cs_b && bank_open != BANKS_IDLE;
  endsequence

  valid_lat_a:
    assert property (s_taken |=> cmd_valid && cmd_out == {1'b0, $past(ras_b), $past(cas_b), $past(we_b)})
    else $error("taken command not decoded one cycle later");
  desel_mask_a:
    assert property (cs_b |=> !cmd_valid)
    else $error("command decoded while deselected");
  row_width_a:
    assert property (cmd_valid && cmd_out == CMD_ACT && !org_x8 |-> !cmd_row[14])
    else $error("row wider than 14 bits on x16");
  page_size_a:
    assert property (page_bytes == (org_x8 ? 12'h400 : 12'h800))
    else $error("page size wrong for organisation");
  act_open_a:
    assert property (cmd_valid && cmd_out == CMD_ACT |-> bank_open[cmd_bank])
    else $error("activated bank not open");
  pre_all_a:
    assert property (cmd_valid && cmd_out == CMD_PRE && cmd_pre_all |-> bank_open == BANKS_IDLE)
    else $error("precharge all left a bank open");
  mrs_write_a:
    assert property (mr_wr |-> mr_sel == $past(bank_addr[1:0]) && mr_opcode == $past(addr))
    else $error("mode register write wrong target or opcode");
  act_pd_a:
    assert property (s_pd_open |=> pwr_state == PWR_ACT_PD)
    else $error("open row did not give active power-down");
  pd_exit_a:
    assert property (pwr_state != PWR_ACTIVE && cke |=> pwr_state == PWR_ACTIVE)
    else $error("no exit on clock enable high");
  pd_gate_a:
    assert property (pwr_state inside {PWR_PRE_PD, PWR_ACT_PD} |-> !in_buf_en && odt_buf_en)
    else $error("power-down buffer gating wrong");
  sr_gate_a:
    assert property (pwr_state == PWR_SELF_REF |-> !in_buf_en && !odt_buf_en && !clk_run)
    else $error("self-refresh buffer gating wrong");
  mask_keep_a:
    assert property (wr_word_valid |-> wr_word_keep == !$past(dm_tdqs))
    else $error("masked word not discarded");
endmodule : dcp_cmd_front_asserts

bind dcp_cmd_front dcp_cmd_front_asserts i_chk (.core_clk, .rst_b, .org_x8, .cke, .cs_b,
  .ras_b, .cas_b, .we_b, .bank_addr, .addr, .dm_tdqs, .cmd_out, .cmd_valid, .cmd_bank,
  .cmd_row, .cmd_pre_all, .page_bytes, .mr_wr, .mr_sel, .mr_opcode, .bank_open,
  .pwr_state, .clk_run, .in_buf_en, .odt_buf_en, .wr_word_valid, .wr_word_keep);
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the command front end
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module tb_top
  import dcp_pkg::*;
;
  logic core_clk, rst_b, org_x8, cke, cs_b, ras_b, cas_b, we_b, odt;
  logic dqs_rise, dqs_fall, dm_tdqs;
  logic [BANK_W-1:0] bank_addr, cmd_bank;
  logic [ADDR_W-1:0] addr, cmd_row, mr_opcode;
  logic [COL_W-1:0] cmd_col;
  logic [PAGE_W-1:0] page_bytes;
  logic [MR_SEL_W-1:0] mr_sel;
  logic [NUM_BANKS-1:0] bank_open;
  dcp_cmd_t cmd_out;
  dcp_pwr_t pwr_state;
  logic cmd_valid, cmd_auto_pre, cmd_pre_all, cmd_burst_full, mr_wr, clk_run, in_buf_en;
  logic out_drv_en, odt_buf_en, term_dq, term_tdqs, tdqs_mode, wr_word_valid, wr_word_keep;
  int n_mismatch;
  int checked;

  dcp_cmd_front i_dut (.core_clk, .rst_b, .org_x8, .cke, .cs_b, .ras_b, .cas_b, .we_b,
    .odt, .bank_addr, .addr, .dqs_rise, .dqs_fall, .dm_tdqs, .cmd_out, .cmd_valid,
    .cmd_bank, .cmd_row, .cmd_col, .cmd_auto_pre, .cmd_pre_all, .cmd_burst_full,
    .page_bytes, .mr_wr, .mr_sel, .mr_opcode, .bank_open, .pwr_state, .clk_run,
    .in_buf_en, .out_drv_en, .odt_buf_en, .term_dq, .term_tdqs, .tdqs_mode,
    .wr_word_valid, .wr_word_keep);
  dcp_ctrl_model i_ctrl (.core_clk, .cke, .cs_b, .ras_b, .cas_b, .we_b, .odt, .bank_addr,
    .addr, .dqs_rise, .dqs_fall, .dm_tdqs);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task t_reset();
    `CHK("cmd_out", CMD_DES, cmd_out)
    `CHK("pwr_state", PWR_ACTIVE, pwr_state)
    `CHK("bank_open", BANKS_IDLE, bank_open)
  endtask : t_reset

  task t_act();
    i_ctrl.cmd(CMD_ACT, 1'b1, 3'h2, 15'h7fff);
    `CHK("cmd_out", CMD_ACT, cmd_out)
    `CHK("cmd_row", 15'h3fff, cmd_row)
    `CHK("bank_open", 8'h04, bank_open)
    `CHK("page_bytes", 12'h800, page_bytes)
    tick(1);
    `CHK("cmd_valid", 1'b0, cmd_valid)
    org_x8 = 1'b1;
    i_ctrl.cmd(CMD_ACT, 1'b1, 3'h7, 15'h7fff);
    `CHK("cmd_row", 15'h7fff, cmd_row)
    `CHK("bank_open", 8'h84, bank_open)
    `CHK("page_bytes", 12'h400, page_bytes)
  endtask : t_act

  task t_desel();
    i_ctrl.cmd(4'hb, 1'b1, 3'h0, 15'h0000);
    `CHK("cmd_valid", 1'b0, cmd_valid)
    i_ctrl.cmd(CMD_NOP, 1'b1, 3'h0, 15'h0000);
    `CHK("cmd_valid", 1'b0, cmd_valid)
    `CHK("bank_open", 8'h84, bank_open)
    i_ctrl.cmd(CMD_ZQC, 1'b1, 3'h0, 15'h0000);
    `CHK("cmd_out", CMD_ZQC, cmd_out)
    i_ctrl.cmd(CMD_REF, 1'b1, 3'h0, 15'h0000);
    `CHK("cmd_out", CMD_REF, cmd_out)
    `CHK("pwr_state", PWR_ACTIVE, pwr_state)
  endtask : t_desel

  task t_access();
    i_ctrl.cmd(CMD_RD, 1'b1, 3'h2, 15'h0555);
    `CHK("cmd_col", 10'h155, cmd_col)
    `CHK("cmd_auto_pre", 1'b1, cmd_auto_pre)
    `CHK("cmd_burst_full", 1'b0, cmd_burst_full)
    `CHK("bank_open", 8'h80, bank_open)
    i_ctrl.cmd(CMD_WR, 1'b1, 3'h7, 15'h1003);
    `CHK("cmd_out", CMD_WR, cmd_out)
    `CHK("cmd_bank", 3'h7, cmd_bank)
    `CHK("cmd_auto_pre", 1'b0, cmd_auto_pre)
    `CHK("cmd_burst_full", 1'b1, cmd_burst_full)
  endtask : t_access

  task t_pre();
    i_ctrl.cmd(CMD_ACT, 1'b1, 3'h1, 15'h0000);
    i_ctrl.cmd(CMD_PRE, 1'b1, 3'h7, 15'h0000);
    `CHK("cmd_pre_all", 1'b0, cmd_pre_all)
    `CHK("bank_open", 8'h02, bank_open)
    i_ctrl.cmd(CMD_PRE, 1'b1, 3'h0, 15'h0400);
    `CHK("cmd_pre_all", 1'b1, cmd_pre_all)
    `CHK("bank_open", 8'h00, bank_open)
  endtask : t_pre

  task t_mrs();
    i_ctrl.cmd(CMD_MRS, 1'b1, 3'h3, 15'h0003);
    `CHK("mr_sel", 2'h3, mr_sel)
    i_ctrl.cmd(CMD_MRS, 1'b1, 3'h1, 15'h0804);
    `CHK("mr_wr", 1'b1, mr_wr)
    `CHK("mr_opcode", 15'h0804, mr_opcode)
    `CHK("tdqs_mode", 1'b1, tdqs_mode)
    i_ctrl.odt = 1'b1;
    tick(2);
    `CHK("term_dq", 1'b1, term_dq)
    `CHK("term_tdqs", 1'b1, term_tdqs)
    i_ctrl.cmd(CMD_MRS, 1'b1, 3'h1, 15'h0000);
    `CHK("tdqs_mode", 1'b0, tdqs_mode)
    tick(2);
    `CHK("term_dq", 1'b0, term_dq)
    i_ctrl.cmd(CMD_MRS, 1'b1, 3'h1, 15'h0004);
  endtask : t_mrs

  task t_write();
    i_ctrl.cmd(CMD_WR, 1'b1, 3'h0, 15'h0000);
    i_ctrl.strobe(1'b1, 1'b1);
    `CHK("wr_word_valid", 1'b1, wr_word_valid)
    `CHK("wr_word_keep", 1'b0, wr_word_keep)
    i_ctrl.strobe(1'b0, 1'b0);
    `CHK("wr_word_valid", 1'b1, wr_word_valid)
    `CHK("wr_word_keep", 1'b1, wr_word_keep)
    // With the pin as termination strobe no word is judged by it
    i_ctrl.cmd(CMD_MRS, 1'b1, 3'h1, 15'h0804);
    i_ctrl.cmd(CMD_WR, 1'b1, 3'h0, 15'h0000);
    i_ctrl.strobe(1'b1, 1'b0);
    `CHK("wr_word_valid", 1'b0, wr_word_valid)
    i_ctrl.cmd(CMD_MRS, 1'b1, 3'h1, 15'h0004);
  endtask : t_write

  task t_power();
    // Clock enable drops only with no access in flight
    i_ctrl.cmd(4'hf, 1'b0, 3'h0, 15'h0000);
    `CHK("pwr_state", PWR_PRE_PD, pwr_state)
    `CHK("in_buf_en", 1'b0, in_buf_en)
    `CHK("odt_buf_en", 1'b1, odt_buf_en)
    i_ctrl.cmd(4'hf, 1'b1, 3'h0, 15'h0000);
    `CHK("in_buf_en", 1'b1, in_buf_en)
    i_ctrl.cmd(CMD_REF, 1'b0, 3'h0, 15'h0000);
    `CHK("pwr_state", PWR_SELF_REF, pwr_state)
    `CHK("odt_buf_en", 1'b0, odt_buf_en)
    `CHK("clk_run", 1'b0, clk_run)
    tick(1);
    `CHK("term_dq", 1'b0, term_dq)
    i_ctrl.cmd(4'hf, 1'b1, 3'h0, 15'h0000);
    `CHK("pwr_state", PWR_ACTIVE, pwr_state)
    `CHK("clk_run", 1'b1, clk_run)
    i_ctrl.cmd(CMD_ACT, 1'b1, 3'h3, 15'h0000);
    i_ctrl.cmd(4'hf, 1'b0, 3'h0, 15'h0000);
    `CHK("pwr_state", PWR_ACT_PD, pwr_state)
    `CHK("out_drv_en", 1'b0, out_drv_en)
    i_ctrl.cmd(4'hf, 1'b1, 3'h0, 15'h0000);
  endtask : t_power

  task stop_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Whole run is about 70 cycles; the 2000-cycle limit leaves ample margin
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    org_x8 = 1'b0;
    n_mismatch = 0;
    checked = 0;
    tick(4);
    rst_b = 1'b1;
    t_reset();
    t_act();
    t_desel();
    t_access();
    t_pre();
    t_mrs();
    t_write();
    t_power();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
